// ### hdl/rfm_consts.vh
`ifndef RFM_CONSTS_VH
`define RFM_CONSTS_VH
// timing figures in their own units
`define RFM_CLK_MHZ 25
`define RFM_ILIM_US 20
`define RFM_THERM_US 20
`define RFM_SHORT_US 1000
`define RFM_SYNC_US 3
`define RFM_OVP_RISE_US 1
`define RFM_OVP_FALL_US 20
`define RFM_PG_US 6
// derived cycle counts
`define RFM_ILIM_CYC (`RFM_ILIM_US * `RFM_CLK_MHZ)
`define RFM_THERM_CYC (`RFM_THERM_US * `RFM_CLK_MHZ)
`define RFM_SHORT_CYC (`RFM_SHORT_US * `RFM_CLK_MHZ)
`define RFM_SYNC_CYC (`RFM_SYNC_US * `RFM_CLK_MHZ)
`define RFM_OVP_RISE_CYC (`RFM_OVP_RISE_US * `RFM_CLK_MHZ)
`define RFM_OVP_FALL_CYC (`RFM_OVP_FALL_US * `RFM_CLK_MHZ)
`define RFM_PG_CYC (`RFM_PG_US * `RFM_CLK_MHZ)
// counter width
`define RFM_CW 16
// regulator count: two bucks, two linear regulators
`define RFM_NREG 4
// device states
`define RFM_ST_SHUTDOWN 2'h0
`define RFM_ST_STANDBY 2'h1
`define RFM_ST_ACTIVE 2'h2
`endif

// ### hdl/rfm_fault_monitor.v
`timescale 1ns/1ps
`include "rfm_consts.vh"
module rfm_fault_monitor #(
    parameter ILIM_CYC = `RFM_ILIM_CYC,
    parameter THERM_CYC = `RFM_THERM_CYC,
    parameter SHORT_CYC = `RFM_SHORT_CYC,
    parameter SYNC_CYC = `RFM_SYNC_CYC,
    parameter OVP_RISE_CYC = `RFM_OVP_RISE_CYC,
    parameter OVP_FALL_CYC = `RFM_OVP_FALL_CYC,
    parameter PG_CYC = `RFM_PG_CYC
) (
    // clock and reset
    input wire mclk_in,
    input wire nrst_in,
    // analog comparator levels, bit0..1 buck, bit2..3 linreg
    input wire [3:0] reg_limiting_in,
    input wire [3:0] reg_output_low_in,
    input wire [3:0] reg_output_pg_in,
    input wire hot_warn_raw_in,
    input wire overtemp_raw_in,
    input wire supply_high_level_in,
    input wire supply_low_lockout_in,
    input wire enable_pin_in,
    // configuration bits
    input wire [3:0] reg_enable_req_in,
    input wire [3:0] discharge_on_in,
    input wire [3:0] limit_irq_block_in,
    input wire hot_warn_irq_block_in,
    input wire reset_irq_block_in,
    input wire soft_reset_request_in,
    input wire shared_pin_function_sel_in,
    input wire [1:0] aux_output_drive_type_in,
    input wire [1:0] aux_output_level_in,
    input wire [1:0] aux_output_sequence_link_in,
    // write-1-to-clear strobes
    input wire [3:0] limit_flag_clr_in,
    input wire [3:0] short_flag_clr_in,
    input wire hot_warn_flag_clr_in,
    input wire supply_high_flag_clr_in,
    input wire overtemp_off_flag_clr_in,
    input wire reset_flag_clr_in,
    // sticky flags
    output wire [3:0] limit_flag_out,
    output wire [3:0] short_flag_out,
    output wire [1:0] buck_summary_flag_out,
    output wire [1:0] linreg_summary_flag_out,
    output wire hot_warn_flag_out,
    output wire supply_high_flag_out,
    output wire overtemp_off_flag_out,
    output wire reset_flag_out,
    // live status
    output wire [3:0] limit_live_out,
    output wire [3:0] running_live_out,
    output wire hot_warn_live_out,
    output wire supply_high_live_out,
    output wire overtemp_off_live_out,
    output wire [3:0] power_ok_live_out,
    output wire [1:0] dev_state_out,
    // regulator drive
    output wire [3:0] switch_on_out,
    output wire [3:0] discharge_out,
    // pins
    output wire irq_out_n,
    output wire aux_output_a_out,
    output wire aux_output_a_oe_out,
    output wire aux_output_b_out,
    output wire aux_output_b_oe_out,
    output wire ext_clock_route_out
);

    ////////////////////////////////////////////////////////////////////////
    // reset release; undervoltage lockout acts as a reset at once
    reg [1:0] rst_sync_ff;
    wire rst_n;
    wire rst_async_n;
    assign rst_async_n = nrst_in & ~supply_low_lockout_in;
    always @(posedge mclk_in or negedge rst_async_n) begin
        if (!rst_async_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // recovery delay: supply must stay up for the sync time, no filtering
    reg [`RFM_CW-1:0] uv_cnt_ff;
    reg uv_ok_ff;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            uv_cnt_ff <= {`RFM_CW{1'b0}};
            uv_ok_ff <= 1'b0;
        end else if (!uv_ok_ff) begin
            uv_cnt_ff <= uv_cnt_ff + 1'b1;
            uv_ok_ff <= (uv_cnt_ff == SYNC_CYC[`RFM_CW-1:0] - 1'b1);
        end
    end

    // enable pin: synchronised only, not held off by the sync delay
    reg [1:0] en_sync_ff;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            en_sync_ff <= 2'h0;
        end else begin
            en_sync_ff <= {en_sync_ff[0], enable_pin_in};
        end
    end
    wire en_pin = en_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // symmetric/asymmetric debounce filters; one counter per signal
    // a window counts consecutive samples that differ from the output
    function [`RFM_CW-1:0] rfm_win;
        input cur;
        input [`RFM_CW-1:0] rise;
        input [`RFM_CW-1:0] fall;
        begin
            rfm_win = cur ? fall : rise;
        end
    endfunction

    localparam NF = 11; // 4 limit, 4 power-good, warn, temp, ovp
    wire [NF-1:0] f_raw;
    reg [NF-1:0] f_out_ff;
    assign f_raw = {supply_high_level_in, overtemp_raw_in, hot_warn_raw_in,
                    reg_output_pg_in, reg_limiting_in};
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi = gi + 1) begin : g_flt
            wire [`RFM_CW-1:0] rise_w;
            wire [`RFM_CW-1:0] fall_w;
            reg [`RFM_CW-1:0] cnt_ff;
            assign rise_w = (gi < 4) ? ILIM_CYC[`RFM_CW-1:0] :
                            (gi < 8) ? PG_CYC[`RFM_CW-1:0] :
                            (gi < 10) ? THERM_CYC[`RFM_CW-1:0] : OVP_RISE_CYC[`RFM_CW-1:0];
            assign fall_w = (gi < 4) ? ILIM_CYC[`RFM_CW-1:0] :
                            (gi < 8) ? PG_CYC[`RFM_CW-1:0] :
                            (gi < 10) ? THERM_CYC[`RFM_CW-1:0] : OVP_FALL_CYC[`RFM_CW-1:0];
            // sampled counter, window accurate to one clock period
            always @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_ff <= {`RFM_CW{1'b0}};
                    f_out_ff[gi] <= 1'b0;
                end else if (f_raw[gi] == f_out_ff[gi]) begin
                    cnt_ff <= {`RFM_CW{1'b0}};
                end else if (cnt_ff == rfm_win(f_out_ff[gi], rise_w, fall_w) - 1'b1) begin
                    cnt_ff <= {`RFM_CW{1'b0}};
                    f_out_ff[gi] <= f_raw[gi];
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    endgenerate

    wire [3:0] limit_live = f_out_ff[3:0];
    wire hot_warn_live = f_out_ff[8];
    wire overtemp_live = f_out_ff[9];
    wire ovp_raw_live = f_out_ff[10];

    ////////////////////////////////////////////////////////////////////////
    // device state
    localparam ST_SHUTDOWN = `RFM_ST_SHUTDOWN;
    localparam ST_STANDBY = `RFM_ST_STANDBY;
    localparam ST_ACTIVE = `RFM_ST_ACTIVE;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [3:0] running_ff;
    reg ovp_flag_ff;
    reg ot_flag_ff;
    // overvoltage only watched outside shutdown
    wire ovp_live = ovp_raw_live & (state_ff != ST_SHUTDOWN);
    // enables refused while a global fault is present or pending
    wire block_all = ovp_live | ovp_flag_ff | overtemp_live | ot_flag_ff;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SHUTDOWN: begin
                if (uv_ok_ff) begin
                    nxt_state = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (|running_ff) begin
                    nxt_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (overtemp_live || ~|running_ff) begin
                    nxt_state = ST_STANDBY;
                end
            end
            default: begin
                nxt_state = ST_SHUTDOWN;
            end
        endcase
    end
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_SHUTDOWN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-regulator short/overload timer and running control
    reg [3:0] short_flag_ff;
    reg [3:0] limit_flag_ff;
    reg [3:0] short_det;
    generate
        for (gi = 0; gi < `RFM_NREG; gi = gi + 1) begin : g_reg
            reg [`RFM_CW-1:0] low_cnt_ff;
            // low after enable or in operation, both need 1 ms continuous
            always @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    low_cnt_ff <= {`RFM_CW{1'b0}};
                end else if (!running_ff[gi] || !reg_output_low_in[gi]) begin
                    low_cnt_ff <= {`RFM_CW{1'b0}};
                end else if (low_cnt_ff != SHORT_CYC[`RFM_CW-1:0]) begin
                    low_cnt_ff <= low_cnt_ff + 1'b1;
                end
            end
            always @* begin
                short_det[gi] = running_ff[gi] && reg_output_low_in[gi] &&
                                (low_cnt_ff == SHORT_CYC[`RFM_CW-1:0] - 1'b1);
            end
            // start only when requested, no short pending, no global block
            always @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    running_ff[gi] <= 1'b0;
                end else if (short_det[gi] || block_all || ovp_raw_live) begin
                    running_ff[gi] <= 1'b0;
                end else begin
                    // restart after short flag clear if still requested
                    running_ff[gi] <= reg_enable_req_in[gi] & ~short_flag_ff[gi] &
                                      (state_ff != ST_SHUTDOWN);
                end
            end
            // sticky flags: set wins over write-1 clear
            always @(posedge mclk_in or negedge rst_n) begin
                if (!rst_n) begin
                    short_flag_ff[gi] <= 1'b0;
                    limit_flag_ff[gi] <= 1'b0;
                end else begin
                    short_flag_ff[gi] <= short_det[gi] | (short_flag_ff[gi] & ~short_flag_clr_in[gi]);
                    limit_flag_ff[gi] <= limit_live[gi] | (limit_flag_ff[gi] & ~limit_flag_clr_in[gi]);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // global sticky flags
    reg warn_flag_ff;
    reg rst_flag_ff;
    reg rst_flag_pend_ff;
    reg soft_rst_ff;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            warn_flag_ff <= 1'b0;
            ovp_flag_ff <= 1'b0;
            ot_flag_ff <= 1'b0;
            rst_flag_pend_ff <= 1'b1;
            rst_flag_ff <= 1'b0;
        end else begin
            warn_flag_ff <= hot_warn_live | (warn_flag_ff & ~hot_warn_flag_clr_in);
            // clear ignored while the condition persists
            ovp_flag_ff <= ovp_live | (ovp_flag_ff & ~supply_high_flag_clr_in);
            ot_flag_ff <= overtemp_live | (ot_flag_ff & ~overtemp_off_flag_clr_in);
            // reset indication, sampled once after release
            rst_flag_pend_ff <= 1'b0;
            // a soft reset request flags itself like a power-up
            rst_flag_ff <= ((rst_flag_pend_ff | soft_rst_ff) & ~reset_irq_block_in) |
                           (rst_flag_ff & ~reset_flag_clr_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // soft reset: request registered each clock, it raises the reset flag and, through soft_hit, the interrupt
    // a trade-off: registers owned by host follow via their own reset
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= soft_reset_request_in;
        end
    end
    // soft reset is folded into sticky state by the reset flag path
    wire soft_hit = soft_rst_ff & ~reset_irq_block_in;

    ////////////////////////////////////////////////////////////////////////
    // interrupt: level, held while any unmasked flag pends
    wire irq_any = |(limit_flag_ff & ~limit_irq_block_in) | (|short_flag_ff) |
                   (warn_flag_ff & ~hot_warn_irq_block_in) | ovp_flag_ff | ot_flag_ff |
                   rst_flag_ff | soft_hit;
    reg irq_n_ff;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= ~irq_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // aux outputs: level, sequence link to enable pin, forced low on ovp
    wire [1:0] aux_lvl = aux_output_level_in & (~aux_output_sequence_link_in | {2{en_pin}});
    wire [1:0] aux_val = ovp_live ? 2'h0 : aux_lvl;
    reg [1:0] aux_ff;
    always @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            aux_ff <= 2'h0;
        end else begin
            aux_ff <= aux_val;
        end
    end
    // open drain drives only the low level
    assign aux_output_a_out = aux_ff[0];
    assign aux_output_a_oe_out = ~aux_output_drive_type_in[0] | ~aux_ff[0];
    assign aux_output_b_out = aux_ff[1];
    assign aux_output_b_oe_out = ~shared_pin_function_sel_in &
                                 (~aux_output_drive_type_in[1] | ~aux_ff[1]);
    assign ext_clock_route_out = shared_pin_function_sel_in;

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign switch_on_out = running_ff;
    assign discharge_out = ~running_ff & discharge_on_in;
    assign running_live_out = running_ff;
    assign limit_flag_out = limit_flag_ff;
    assign short_flag_out = short_flag_ff;
    assign buck_summary_flag_out = short_flag_ff[1:0];
    assign linreg_summary_flag_out = short_flag_ff[3:2];
    assign hot_warn_flag_out = warn_flag_ff;
    assign supply_high_flag_out = ovp_flag_ff;
    assign overtemp_off_flag_out = ot_flag_ff;
    assign reset_flag_out = rst_flag_ff;
    assign limit_live_out = limit_live;
    assign hot_warn_live_out = hot_warn_live;
    assign supply_high_live_out = ovp_live;
    assign overtemp_off_live_out = overtemp_live;
    assign power_ok_live_out = f_out_ff[7:4];
    assign dev_state_out = state_ff;
    assign irq_out_n = irq_n_ff;

endmodule // rfm_fault_monitor

// ### test/rfm_fault_monitor_properties.sv
`timescale 1ns/1ps
module rfm_fault_monitor_properties (
    // clock and resets
    input wire mclk_in,
    input wire nrst_in,
    input wire supply_low_lockout_in,
    // watched configuration
    input wire [3:0] discharge_on_in,
    input wire [3:0] limit_irq_block_in,
    input wire shared_pin_function_sel_in,
    // watched outputs
    input wire [3:0] limit_live_out,
    input wire [3:0] limit_flag_out,
    input wire [3:0] short_flag_out,
    input wire [1:0] buck_summary_flag_out,
    input wire supply_high_flag_out,
    input wire supply_high_live_out,
    input wire overtemp_off_flag_out,
    input wire overtemp_off_live_out,
    input wire [3:0] running_live_out,
    input wire [3:0] discharge_out,
    input wire [1:0] dev_state_out,
    input wire irq_out_n,
    input wire aux_output_a_out,
    input wire aux_output_b_oe_out,
    input wire ext_clock_route_out
);
    // lockout resets the block as hard as the pin does
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in || supply_low_lockout_in);
    ////////////////////////////////////////////
    a_limit_flag_set: assert property ($rose(limit_live_out[0]) |=> limit_flag_out[0])
        else $error("limit flag did not follow live limit");
    a_irq_unmasked: assert property (|(limit_flag_out & ~limit_irq_block_in) |=> !irq_out_n)
        else $error("irq released with unmasked flag pending");
    a_short_summary: assert property ($rose(short_flag_out[0]) |-> ##[0:1] buck_summary_flag_out[0])
        else $error("summary flag missing on short");
    a_short_stops: assert property ($rose(short_flag_out[0]) |-> ##[0:1] !running_live_out[0])
        else $error("regulator still running after short");
    a_discharge_gate: assert property (discharge_out == (~running_live_out & discharge_on_in))
        else $error("discharge not gated by enable bit");
    a_ovp_sticky: assert property (supply_high_live_out && supply_high_flag_out |=> supply_high_flag_out)
        else $error("overvoltage flag cleared while present");
    a_hot_sticky: assert property (overtemp_off_live_out && overtemp_off_flag_out |=> overtemp_off_flag_out)
        else $error("overtemp flag cleared while hot");
    a_ovp_shutoff: assert property (supply_high_live_out [*2] |-> running_live_out == 4'h0 && !aux_output_a_out)
        else $error("outputs active during overvoltage");
    a_enable_refused: assert property ((supply_high_flag_out || overtemp_off_flag_out) [*2] |->
        running_live_out == 4'h0)
        else $error("regulator enabled with fault pending");
    a_ot_standby: assert property (overtemp_off_flag_out [*2] |-> dev_state_out == 2'h1)
        else $error("not in standby after overtemp");
    a_pin_shared: assert property (shared_pin_function_sel_in |-> ext_clock_route_out && !aux_output_b_oe_out)
        else $error("shared pin driven while clock selected");
    // main scenarios reached
    c_limit: cover property ($rose(limit_flag_out[3]));
    c_short: cover property ($rose(short_flag_out[2]));
    c_ovp: cover property ($rose(supply_high_flag_out));
    c_hot: cover property ($rose(overtemp_off_flag_out));
endmodule // rfm_fault_monitor_properties

bind rfm_fault_monitor rfm_fault_monitor_properties i_rfm_fault_monitor_properties (.*);

// ### test/rfm_host_model.sv
`timescale 1ns/1ps
module rfm_host_model (
    // clock
    input wire mclk_in,
    // write-1 strobes: limit, short, warn, high, hot, reset
    output reg [11:0] clr_out
);
    initial clr_out = 12'h000;
    // one-cycle pulse, launched away from the sampling edge
    task write_clear(input [11:0] bits);
        begin
            @(negedge mclk_in);
            clr_out = bits;
            @(negedge mclk_in);
            clr_out = 12'h000;
        end
    endtask
endmodule // rfm_host_model

// ### test/rfm_fault_monitor_bench.sv
`timescale 1ns/1ps
module rfm_fault_monitor_bench;
    // short windows keep the run brief
    localparam IL = 6, SH = 8, SY = 4, OVR = 4, OVF = 6;
    reg mclk_in = 1'b0, nrst_in = 1'b0;
    reg [3:0] reg_limiting_in = 4'h0, reg_output_low_in = 4'h0, reg_output_pg_in = 4'hf;
    reg [3:0] reg_enable_req_in = 4'h0, discharge_on_in = 4'h0, limit_irq_block_in = 4'h0;
    reg hot_warn_raw_in = 1'b0, overtemp_raw_in = 1'b0, supply_high_level_in = 1'b0, supply_low_lockout_in = 1'b0;
    reg enable_pin_in = 1'b1, hot_warn_irq_block_in = 1'b0, reset_irq_block_in = 1'b0;
    reg soft_reset_request_in = 1'b0, shared_pin_function_sel_in = 1'b0;
    reg [1:0] aux_output_drive_type_in = 2'h0, aux_output_level_in = 2'h0, aux_output_sequence_link_in = 2'h0;
    wire [3:0] limit_flag_out, short_flag_out, limit_live_out, running_live_out, power_ok_live_out;
    wire [3:0] switch_on_out, discharge_out;
    wire [1:0] buck_summary_flag_out, linreg_summary_flag_out, dev_state_out;
    wire hot_warn_flag_out, supply_high_flag_out, overtemp_off_flag_out, reset_flag_out, hot_warn_live_out;
    wire supply_high_live_out, overtemp_off_live_out, irq_out_n, aux_output_a_out, aux_output_a_oe_out;
    wire aux_output_b_out, aux_output_b_oe_out, ext_clock_route_out;
    wire [11:0] clr;
    wire [3:0] summary = {linreg_summary_flag_out, buck_summary_flag_out};
    integer n_fail = 0, n_tests = 0, i;

    rfm_fault_monitor #(.ILIM_CYC(IL), .THERM_CYC(IL), .SHORT_CYC(SH), .SYNC_CYC(SY), .OVP_RISE_CYC(OVR),
        .OVP_FALL_CYC(OVF), .PG_CYC(5)) i_rfm_fault_monitor (.*, .limit_flag_clr_in(clr[3:0]),
        .short_flag_clr_in(clr[7:4]), .hot_warn_flag_clr_in(clr[8]), .supply_high_flag_clr_in(clr[9]),
        .overtemp_off_flag_clr_in(clr[10]), .reset_flag_clr_in(clr[11]));
    rfm_host_model i_host (.mclk_in(mclk_in), .clr_out(clr));

    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;
    ////////////////////////////////////////////
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge mclk_in);
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////
    // sequence of scenarios, inputs moved on falling edges
    initial begin
        wt(2);
        nrst_in = 1'b1;
        wt(SY + 6);
        chk({dev_state_out, reset_flag_out, irq_out_n}, 4'h6);
        i_host.write_clear(12'h800);
        wt(3);
        chk(irq_out_n, 1'b1);
        $display("reset test done");
        // short pulse filtered, long one flags; top regulator masked
        limit_irq_block_in = 4'h8;
        for (i = 0; i < 4; i = i + 1) begin
            reg_limiting_in[i] = 1'b1;
            wt(IL - 2);
            reg_limiting_in[i] = 1'b0;
            wt(IL + 3);
            chk(limit_flag_out[i], 1'b0);
            reg_limiting_in[i] = 1'b1;
            wt(IL + 3);
            chk({limit_live_out[i], limit_flag_out[i], irq_out_n}, {2'h3, i == 3});
            reg_limiting_in[i] = 1'b0;
            wt(IL + 2);
            chk({limit_live_out[i], limit_flag_out[i]}, 2'h1);
            i_host.write_clear(12'h001 << i);
            wt(3);
            chk({limit_flag_out[i], irq_out_n}, 2'h1);
        end
        $display("limit test done");
        hot_warn_raw_in = 1'b1;
        wt(IL + 3);
        chk({hot_warn_live_out, hot_warn_flag_out, irq_out_n}, 3'h6);
        hot_warn_raw_in = 1'b0;
        wt(IL + 2);
        i_host.write_clear(12'h100);
        wt(3);
        chk({hot_warn_flag_out, irq_out_n}, 2'h1);
        hot_warn_irq_block_in = 1'b1;
        hot_warn_raw_in = 1'b1;
        wt(IL + 3);
        chk({hot_warn_flag_out, irq_out_n}, 2'h3);
        hot_warn_raw_in = 1'b0;
        wt(IL + 2);
        i_host.write_clear(12'h100);
        $display("warning test done");
        // odd regulators start into a short, even ones overload later
        for (i = 0; i < 4; i = i + 1) begin
            discharge_on_in = i[0] ? 4'h0 : 4'hf;
            reg_output_low_in[i] = i[0];
            reg_enable_req_in[i] = 1'b1;
            wt(10);
            chk(running_live_out[i] | i[0], 1'b1);
            reg_output_low_in[i] = 1'b1;
            wt(SH + 4);
            chk({short_flag_out[i], summary[i], running_live_out[i], irq_out_n}, 4'hc);
            chk(discharge_out[i], !i[0]);
            reg_output_low_in[i] = 1'b0;
            i_host.write_clear(12'h010 << i);
            wt(10);
            chk({short_flag_out[i], running_live_out[i]}, 2'h1);
            reg_enable_req_in[i] = 1'b0;
            wt(3);
        end
        $display("short test done");
        aux_output_level_in = 2'h3;
        reg_enable_req_in = 4'h1;
        wt(10);
        chk({dev_state_out, running_live_out[0], aux_output_a_out}, 4'hb);
        supply_high_level_in = 1'b1;
        wt(OVR - 2);
        supply_high_level_in = 1'b0;
        wt(3);
        chk(supply_high_flag_out, 1'b0);
        supply_high_level_in = 1'b1;
        wt(OVR + 3);
        chk({supply_high_live_out, supply_high_flag_out, irq_out_n}, 3'h6);
        chk({running_live_out, aux_output_a_out}, 5'h00);
        i_host.write_clear(12'h200);
        wt(2);
        chk(supply_high_flag_out, 1'b1);
        supply_high_level_in = 1'b0;
        wt(OVF - 2);
        chk(supply_high_live_out, 1'b1);
        wt(5);
        chk({supply_high_live_out, running_live_out[0]}, 2'h0);
        i_host.write_clear(12'h200);
        wt(10);
        chk({supply_high_flag_out, running_live_out[0]}, 2'h1);
        $display("overvoltage test done");
        overtemp_raw_in = 1'b1;
        wt(IL + 3);
        chk({overtemp_off_live_out, overtemp_off_flag_out, irq_out_n, running_live_out[0]}, 4'hc);
        chk(dev_state_out, 2'h1);
        i_host.write_clear(12'h400);
        wt(2);
        chk(overtemp_off_flag_out, 1'b1);
        overtemp_raw_in = 1'b0;
        wt(IL + 3);
        chk(running_live_out[0], 1'b0);
        i_host.write_clear(12'h400);
        wt(10);
        chk({overtemp_off_flag_out, running_live_out[0]}, 2'h1);
        $display("overtemp test done");
        // lockout acts without waiting for a clock edge
        supply_low_lockout_in = 1'b1;
        #2;
        chk({dev_state_out, running_live_out}, 6'h00);
        reg_enable_req_in = 4'h0;
        wt(2);
        supply_low_lockout_in = 1'b0;
        wt(SY + 6);
        chk({dev_state_out, reset_flag_out}, 3'h3);
        i_host.write_clear(12'h800);
        // soft reset flags like a lockout; the mask keeps it quiet
        reset_irq_block_in = 1'b1;
        soft_reset_request_in = 1'b1;
        wt(3);
        chk({reset_flag_out, irq_out_n}, 2'h1);
        reset_irq_block_in = 1'b0;
        wt(3);
        chk({reset_flag_out, irq_out_n}, 2'h2);
        soft_reset_request_in = 1'b0;
        i_host.write_clear(12'h800);
        wt(3);
        chk({reset_flag_out, irq_out_n}, 2'h1);
        $display("lockout test done");
        // open drain high releases the pin; clock select frees it
        aux_output_drive_type_in = 2'h3;
        aux_output_level_in = 2'h1;
        shared_pin_function_sel_in = 1'b1;
        wt(3);
        chk({aux_output_a_out, aux_output_a_oe_out, ext_clock_route_out, aux_output_b_oe_out}, 4'ha);
        aux_output_drive_type_in = 2'h2;
        shared_pin_function_sel_in = 1'b0;
        wt(3);
        chk({aux_output_a_oe_out, aux_output_b_oe_out, ext_clock_route_out}, 3'h6);
        // sequence link ties output a to the synchronised enable pin
        aux_output_level_in = 2'h3;
        aux_output_sequence_link_in = 2'h1;
        enable_pin_in = 1'b0;
        wt(3);
        chk({aux_output_a_out, aux_output_b_out, switch_on_out}, 6'h10);
        enable_pin_in = 1'b1;
        wt(3);
        chk({aux_output_a_out, aux_output_b_out}, 2'h3);
        // power-good moves only once its window has run out
        reg_output_pg_in = 4'h5;
        wt(4);
        chk(power_ok_live_out, 4'hf);
        wt(2);
        chk(power_ok_live_out, 4'h5);
        $display("aux pin test done");
        wrap_up;
    end
    // watchdog far beyond the expected span
    initial begin
        #(40 * 4000);
        n_fail = n_fail + 1;
        $display("ERROR at %0t: watchdog expired", $time);
        wrap_up;
    end
endmodule // rfm_fault_monitor_bench
